// [design/lsbas_top.sv]
// LIN slave baud-rate unit: APB registers, divider copies, synch-field measurement,
// header and mute handling around a 16x oversampled receiver.
// Assumes receive_line is synchronous to pclk and an APB master drives the bus.
`timescale 1ns/10ps
`include "lsbas_cfg.svh"

// How it works
// - Baud from software divider or measured synch
// - Count clocks across five synch falling edges
// - Fifth edge loads measured into active, readable
// - Receiver halted while synch field measured
// - Master mode uses conventional or extended prescaler
// - Slave mode: clock over sixteen times divider
// - Divider is 8.4 unsigned fixed point
// - Keep nominal, measured and active divider copies
// - Software load beats measured load same cycle
// - Master break thirteen bits, fifteen percent margin
// - Break accepted only after eleven low bits
// - Sixteen samples, majority of 8th-10th
// - Sampling phase realigned on each start edge
// - Measurement spans eight bits, clocked counter
// - Mute wakes on break or identifier
// - Hot plug: discard until eleven dominant bits
// - Update method: immediate or next character
// - Enable and slave-select choose LIN mode
// - Divider registers at conventional baud addresses
module lsbas_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        receive_line,
  output logic             os_tick,
  output logic             synch_active,
  output logic             header_flag
);
  lsbas_pkg::lsbas_ctrl_type  ctrl_ff;
  lsbas_pkg::lsbas_sync_type  sync_ff;
  lsbas_pkg::lsbas_rx_ev_type rx_ev;

  logic [7:0]  conventional_baud_reg_ff;
  logic [7:0]  extended_baud_reg_ff;
  logic [11:0] nominal_divider_ff;
  logic [11:0] measured_divider;
  logic [11:0] active_slave_divider_ff;
  logic [11:0] gen_divider;
  logic [14:0] synch_measure_count_ff;
  logic [2:0]  edges_ff;
  logic        line_q_ff;
  logic        pend_load_ff;
  logic        rdy_ff;
  logic [7:0]  data_ff;
  logic [1:0]  chars_ff;
  logic        hdr_wait_ff;

  logic        setup;
  logic        wr_en;
  logic        rd_en;
  logic        slave_mode;
  logic        master_mode;
  logic        fall;
  logic        meas_done;
  logic        sw_load;
  logic        byte_ok;
  logic        id_done;
  logic        mapped;

  // Zero wait states: read data is registered in the setup cycle, writes land in the access cycle
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == `LSBAS_OFF_MANT) || (paddr == `LSBAS_OFF_FRAC) ||
                  (paddr == `LSBAS_OFF_CTRL) || (paddr == `LSBAS_OFF_STAT) ||
                  (paddr == `LSBAS_OFF_DATA);

  assign master_mode = ctrl_ff.line & ~ctrl_ff.slv;
  assign slave_mode  = ctrl_ff.line & ctrl_ff.slv;

  // Conventional prescaler is the integer divider; a nonzero extended one overrides it
  always_comb begin
    if (slave_mode) begin
      gen_divider = active_slave_divider_ff;
    end else if (extended_baud_reg_ff != 8'h00) begin
      gen_divider = {extended_baud_reg_ff, 4'h0};
    end else begin
      gen_divider = {conventional_baud_reg_ff, 4'h0};
    end
  end

  lsbas_baud_gen u_lsbas_baud_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .divider (gen_divider),
    .os_tick (os_tick)
  );

  assign synch_active = (sync_ff != lsbas_pkg::SYNC_IDLE);

  lsbas_rx u_lsbas_rx (
    .pclk         (pclk),
    .presetn      (presetn),
    .os_tick      (os_tick),
    .receive_line (receive_line),
    .halt         (synch_active),
    .rx_ev        (rx_ev)
  );

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= '0;
    end else begin
      if (wr_en && paddr == `LSBAS_OFF_CTRL) begin
        ctrl_ff.dum  <= pwdata[`LSBAS_CTRL_DUM];
        ctrl_ff.line <= pwdata[`LSBAS_CTRL_LINE];
        ctrl_ff.slv  <= pwdata[`LSBAS_CTRL_SLV];
        ctrl_ff.ase  <= pwdata[`LSBAS_CTRL_ASE];
        ctrl_ff.hdm  <= pwdata[`LSBAS_CTRL_HDM];
        ctrl_ff.mute <= pwdata[`LSBAS_CTRL_MUTE];
      end
      // Deferred update completes on the next character and drops the method bit
      if (slave_mode && ctrl_ff.dum && rx_ev.byte_valid) begin
        ctrl_ff.dum <= 1'b0;
      end
      // Wake: break when hdm clear, full identifier when set
      if (slave_mode && ctrl_ff.mute) begin
        if ((!ctrl_ff.hdm && rx_ev.brk) || (ctrl_ff.hdm && id_done)) begin
          ctrl_ff.mute <= 1'b0;
        end
      end
    end
  end

  // Outside slave mode the first two offsets hold the conventional prescalers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conventional_baud_reg_ff <= 8'h00;
      extended_baud_reg_ff     <= 8'h00;
    end else if (wr_en && !slave_mode) begin
      if (paddr == `LSBAS_OFF_MANT) begin
        conventional_baud_reg_ff <= pwdata[7:0];
      end
      if (paddr == `LSBAS_OFF_FRAC) begin
        extended_baud_reg_ff <= pwdata[7:0];
      end
    end
  end

  // Nominal copy takes every slave-mode prescaler write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nominal_divider_ff <= `LSBAS_DIV_RESET;
    end else if (wr_en && slave_mode) begin
      if (paddr == `LSBAS_OFF_MANT) begin
        nominal_divider_ff[11:4] <= pwdata[7:0];
      end
      if (paddr == `LSBAS_OFF_FRAC) begin
        nominal_divider_ff[3:0] <= pwdata[3:0];
      end
    end
  end

  // Mantissa write loads the active copy now, or arms a load for the next character
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_load_ff <= 1'b0;
    end else if (wr_en && slave_mode && paddr == `LSBAS_OFF_MANT && ctrl_ff.dum) begin
      pend_load_ff <= 1'b1;
    end else if (sw_load || !ctrl_ff.dum) begin
      pend_load_ff <= 1'b0;
    end
  end

  assign sw_load = slave_mode && (
                   (wr_en && paddr == `LSBAS_OFF_MANT && !ctrl_ff.dum) ||
                   (ctrl_ff.dum && rx_ev.byte_valid));

  // Count of clocks over eight bit times is 128 divider units, so 8.4 is count/8
  assign measured_divider = synch_measure_count_ff[14:`LSBAS_MEAS_SHIFT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_slave_divider_ff <= `LSBAS_DIV_RESET;
    end else if (sw_load) begin
      // An immediate-mode (dum clear) mantissa write in the same cycle as a measured load keeps the software value
      if (wr_en && paddr == `LSBAS_OFF_MANT) begin
        active_slave_divider_ff <= {pwdata[7:0], nominal_divider_ff[3:0]};
      end else begin
        active_slave_divider_ff <= nominal_divider_ff;
      end
    end else if (meas_done) begin
      active_slave_divider_ff <= measured_divider;
    end
  end

  // Synch field measurement, counter and edge detector both on pclk
  assign fall = line_q_ff & ~receive_line;
  assign meas_done = (sync_ff == lsbas_pkg::SYNC_COUNT) && fall &&
                     (edges_ff == `LSBAS_SYNC_EDGES - 3'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q_ff <= 1'b1;
    end else begin
      line_q_ff <= receive_line;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ff                <= lsbas_pkg::SYNC_IDLE;
      edges_ff               <= 3'h0;
      synch_measure_count_ff <= 15'h0000;
    end else begin
      case (sync_ff)
        lsbas_pkg::SYNC_IDLE: begin
          // Breaks are trusted only as the master sends them long enough
          if (slave_mode && ctrl_ff.ase && rx_ev.brk) begin
            sync_ff <= lsbas_pkg::SYNC_WAIT;
          end
        end
        lsbas_pkg::SYNC_WAIT: begin
          if (!slave_mode || !ctrl_ff.ase) begin
            sync_ff <= lsbas_pkg::SYNC_IDLE;
          end else if (fall) begin
            sync_ff                <= lsbas_pkg::SYNC_COUNT;
            edges_ff               <= 3'h1;
            synch_measure_count_ff <= 15'h0001;
          end
        end
        lsbas_pkg::SYNC_COUNT: begin
          if (!slave_mode || !ctrl_ff.ase || meas_done) begin
            sync_ff <= lsbas_pkg::SYNC_IDLE;
          end else begin
            if (fall) begin
              edges_ff <= edges_ff + 3'h1;
            end
            // Saturates rather than wrapping so an overlong field gives the largest divider
            if (synch_measure_count_ff != `LSBAS_MEAS_MAX) begin
              synch_measure_count_ff <= synch_measure_count_ff + 15'h0001;
            end
          end
        end
        default: begin
          sync_ff <= lsbas_pkg::SYNC_IDLE;
        end
      endcase
    end
  end

  // Identifier is the first character after the break when synch was measured,
  // otherwise the second (synch arrives as a character)
  assign id_done = hdr_wait_ff && rx_ev.byte_valid &&
                   (ctrl_ff.ase ? (chars_ff == 2'h0) : (chars_ff == 2'h1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_wait_ff <= 1'b0;
      chars_ff    <= 2'h0;
    end else if (rx_ev.brk && slave_mode) begin
      hdr_wait_ff <= 1'b1;
      chars_ff    <= 2'h0;
    end else if (id_done) begin
      hdr_wait_ff <= 1'b0;
    end else if (hdr_wait_ff && rx_ev.byte_valid) begin
      chars_ff <= chars_ff + 2'h1;
    end
  end

  // Header flag: set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      header_flag <= 1'b0;
    end else if (slave_mode && ((!ctrl_ff.hdm && rx_ev.brk) || (ctrl_ff.hdm && id_done))) begin
      header_flag <= 1'b1;
    end else if (wr_en && paddr == `LSBAS_OFF_STAT && pwdata[`LSBAS_STAT_HDR]) begin
      header_flag <= 1'b0;
    end
  end

  // While muted every character but the identifier that wakes it (hdm set) is dropped, which is how a late joiner waits for a header
  assign byte_ok = rx_ev.byte_valid && (!ctrl_ff.mute || id_done);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_ff  <= 1'b0;
      data_ff <= 8'h00;
    end else if (byte_ok) begin
      rdy_ff  <= 1'b1;
      data_ff <= rx_ev.data;
    end else if (rd_en && paddr == `LSBAS_OFF_DATA) begin
      rdy_ff <= 1'b0;
    end
  end

  // Read data and error are registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~mapped;
      prdata  <= 32'h0000_0000;
      case (paddr)
        `LSBAS_OFF_MANT: begin
          prdata[7:0] <= slave_mode ? active_slave_divider_ff[11:4] : conventional_baud_reg_ff;
        end
        `LSBAS_OFF_FRAC: begin
          prdata[7:0] <= slave_mode ? {4'h0, active_slave_divider_ff[3:0]} : extended_baud_reg_ff;
        end
        `LSBAS_OFF_CTRL: begin
          prdata[`LSBAS_CTRL_DUM]  <= ctrl_ff.dum;
          prdata[`LSBAS_CTRL_LINE] <= ctrl_ff.line;
          prdata[`LSBAS_CTRL_SLV]  <= ctrl_ff.slv;
          prdata[`LSBAS_CTRL_ASE]  <= ctrl_ff.ase;
          prdata[`LSBAS_CTRL_HDM]  <= ctrl_ff.hdm;
          prdata[`LSBAS_CTRL_MUTE] <= ctrl_ff.mute;
        end
        `LSBAS_OFF_STAT: begin
          prdata[`LSBAS_STAT_SYNC] <= synch_active;
          prdata[`LSBAS_STAT_HDR]  <= header_flag;
          prdata[`LSBAS_STAT_RDY]  <= rdy_ff;
          prdata[`LSBAS_STAT_PEND] <= pend_load_ff;
        end
        `LSBAS_OFF_DATA: begin
          prdata[7:0] <= data_ff;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule

// [design/lsbas_cfg.svh]
// Offsets, field positions, reset values and counts of the LIN slave baud unit.
// Included by the design and bench modules; definitions only.
`ifndef LSBAS_CFG_SVH
`define LSBAS_CFG_SVH

`define LSBAS_OFF_MANT       8'h00
`define LSBAS_OFF_FRAC       8'h04
`define LSBAS_OFF_CTRL       8'h08
`define LSBAS_OFF_STAT       8'h0C
`define LSBAS_OFF_DATA       8'h10

`define LSBAS_CTRL_MUTE      1
`define LSBAS_CTRL_HDM       3
`define LSBAS_CTRL_ASE       4
`define LSBAS_CTRL_SLV       5
`define LSBAS_CTRL_LINE      6
`define LSBAS_CTRL_DUM       7

`define LSBAS_STAT_SYNC      0
`define LSBAS_STAT_HDR       1
`define LSBAS_STAT_RDY       2
`define LSBAS_STAT_PEND      3

`define LSBAS_DIV_RESET      12'h010
`define LSBAS_OS_RATE        5'h10
`define LSBAS_SAMPLE_FIRST   4'h7
`define LSBAS_SAMPLE_LAST    4'h9
`define LSBAS_BIT_LAST       4'h9
`define LSBAS_BREAK_BITS     11
`define LSBAS_BREAK_TICKS    8'hB0
`define LSBAS_SYNC_EDGES     3'h5
`define LSBAS_MEAS_SHIFT     3
`define LSBAS_MEAS_MAX       15'h7FFF

`endif

// [design/lsbas_pkg.sv]
// Types shared by the LIN slave baud unit.
// Assumes lsbas_cfg.svh is on the include path.
package lsbas_pkg;

  typedef enum logic [1:0] {
    SYNC_IDLE,
    SYNC_WAIT,
    SYNC_COUNT
  } lsbas_sync_type;

  typedef struct packed {
    logic       byte_valid;
    logic [7:0] data;
    logic       brk;
  } lsbas_rx_ev_type;

  typedef struct packed {
    logic dum;
    logic line;
    logic slv;
    logic ase;
    logic hdm;
    logic mute;
  } lsbas_ctrl_type;

endpackage

// [design/lsbas_baud_gen.sv]
// Fractional 16x oversampling tick generator, divider in 8.4 fixed point.
// Assumes the divider only changes between ticks; a zero divider stops ticks.
`timescale 1ns/10ps
`include "lsbas_cfg.svh"
module lsbas_baud_gen (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] divider,
  output logic             os_tick
);
  logic [11:0] acc_ff;
  logic [12:0] nxt_sum;

  // Adds one whole unit per clock, so a tick comes every divider/16 clocks on average
  assign nxt_sum = {1'b0, acc_ff} + 13'h0010;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff  <= 12'h000;
      os_tick <= 1'b0;
    end else if (divider == 12'h000) begin
      acc_ff  <= 12'h000;
      os_tick <= 1'b0;
    end else if (nxt_sum >= {1'b0, divider}) begin
      acc_ff  <= 12'(nxt_sum - {1'b0, divider});
      os_tick <= 1'b1;
    end else begin
      acc_ff  <= nxt_sum[11:0];
      os_tick <= 1'b0;
    end
  end
endmodule

// [design/lsbas_rx.sv]
// Oversampled character receiver with break detection.
// Assumes os_tick pulses sixteen times per bit and receive_line is synchronous.
`timescale 1ns/10ps
`include "lsbas_cfg.svh"
module lsbas_rx (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     os_tick,
  input  wire logic                     receive_line,
  input  wire logic                     halt,
  output lsbas_pkg::lsbas_rx_ev_type    rx_ev
);
  logic       busy_ff;
  logic       line_q_ff;
  logic [3:0] os_cnt_ff;
  logic [3:0] bit_idx_ff;
  logic [2:0] samp_ff;
  logic [7:0] shift_ff;
  logic [7:0] low_run_ff;
  logic       bit_val;
  logic       byte_valid_ff;
  logic [7:0] data_ff;
  logic       brk_ff;

  // One driver per field: the event struct is assembled from separate flops
  assign rx_ev = '{byte_valid: byte_valid_ff, data: data_ff, brk: brk_ff};

  assign bit_val = (samp_ff[0] & samp_ff[1]) | (samp_ff[1] & samp_ff[2]) | (samp_ff[0] & samp_ff[2]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q_ff <= 1'b1;
    end else begin
      line_q_ff <= receive_line;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff    <= 1'b0;
      os_cnt_ff  <= 4'h0;
      bit_idx_ff <= 4'h0;
      samp_ff    <= 3'h0;
      shift_ff   <= 8'h00;
      byte_valid_ff <= 1'b0;
      data_ff    <= 8'h00;
    end else begin
      byte_valid_ff <= 1'b0;
      if (halt) begin
        busy_ff <= 1'b0;
      end else if (!busy_ff) begin
        if (line_q_ff && !receive_line) begin
          busy_ff    <= 1'b1;
          os_cnt_ff  <= 4'h0;
          bit_idx_ff <= 4'h0;
        end
      end else if (os_tick) begin
        os_cnt_ff <= os_cnt_ff + 4'h1;
        if (os_cnt_ff >= `LSBAS_SAMPLE_FIRST && os_cnt_ff <= `LSBAS_SAMPLE_LAST) begin
          samp_ff <= {samp_ff[1:0], receive_line};
        end
        if (os_cnt_ff == 4'hF) begin
          bit_idx_ff <= bit_idx_ff + 4'h1;
          if (bit_idx_ff == 4'h0 && bit_val) begin
            busy_ff <= 1'b0;
          end else if (bit_idx_ff == `LSBAS_BIT_LAST) begin
            busy_ff <= 1'b0;
            // A low stop bit is a framing error or part of a break: no character
            if (bit_val) begin
              byte_valid_ff <= 1'b1;
              data_ff       <= shift_ff;
            end
          end else if (bit_idx_ff != 4'h0) begin
            shift_ff <= {bit_val, shift_ff[7:1]};
          end
        end
      end
    end
  end

  // Break needs eleven low bit times ended by a high level; nine low bits never qualify
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_run_ff <= 8'h00;
      brk_ff     <= 1'b0;
    end else begin
      brk_ff <= 1'b0;
      if (receive_line) begin
        brk_ff     <= (low_run_ff >= `LSBAS_BREAK_TICKS);
        low_run_ff <= 8'h00;
      end else if (os_tick && low_run_ff < `LSBAS_BREAK_TICKS) begin
        low_run_ff <= low_run_ff + 8'h01;
      end
    end
  end
endmodule

// [bench/lsbas_top_chk.sv]
// Port-level checks of the LIN slave baud unit.
// Assumes a divider of at least 1.0, so a bit lasts at least 16 clocks.
`timescale 1ns/10ps
`include "lsbas_cfg.svh"
module lsbas_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        receive_line,
  input wire logic        os_tick,
  input wire logic        synch_active,
  input wire logic        header_flag
);
  logic [15:0] low_run_ff;
  logic [15:0] last_low_ff;
  logic [15:0] syn_cnt_ff;
  logic        unmap;
  logic        hdr_clr;
  logic        div_rd;

  assign unmap = !(paddr inside {`LSBAS_OFF_MANT, `LSBAS_OFF_FRAC, `LSBAS_OFF_CTRL, `LSBAS_OFF_STAT, `LSBAS_OFF_DATA});
  assign hdr_clr = psel && penable && pwrite && (paddr == `LSBAS_OFF_STAT) && pwdata[`LSBAS_STAT_HDR];
  assign div_rd = psel && penable && !pwrite && (paddr == `LSBAS_OFF_MANT || paddr == `LSBAS_OFF_FRAC);

  // Length of the most recent dominant stretch on the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_run_ff <= 16'h0000;
      last_low_ff <= 16'h0000;
    end else if (!receive_line) begin
      if (low_run_ff != 16'hFFFF) low_run_ff <= low_run_ff + 16'h0001;
    end else begin
      if (low_run_ff != 16'h0000) last_low_ff <= low_run_ff;
      low_run_ff <= 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) syn_cnt_ff <= 16'h0000;
    else if (synch_active) syn_cnt_ff <= syn_cnt_ff + 16'h0001;
    else syn_cnt_ff <= 16'h0000;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PREADY_HIGH: assert property (psel && penable |-> pready)
    else $error("pready low");
  AST_UNMAPPED_ERR: assert property (psel && !penable && unmap |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (psel && !penable && !unmap |=> !pslverr)
    else $error("mapped access refused");
  AST_DIV_WIDTH: assert property (div_rd |-> prdata[31:8] == 24'h00_0000)
    else $error("divider read too wide");
  // Slack of a few clocks covers edge detection and tick phase
  AST_BREAK_LEN: assert property ($rose(synch_active) |-> receive_line && last_low_ff >= 16'd170)
    else $error("synch started after a short dominant stretch");
  AST_SYNCH_END: assert property ($fell(synch_active) |-> !receive_line)
    else $error("synch ended away from a falling edge");
  AST_SYNCH_SPAN: assert property ($fell(synch_active) |-> syn_cnt_ff >= 16'd128)
    else $error("synch measurement too short");
  AST_HDR_STICKY: assert property (header_flag && !hdr_clr |=> header_flag)
    else $error("header flag lost without clear");

  COV_SYNCH_DONE: cover property ($fell(synch_active));
  COV_UNMAPPED: cover property (psel && penable && pslverr);
  COV_HEADER: cover property ($rose(header_flag));
endmodule

bind lsbas_top lsbas_chk u_lsbas_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .receive_line(receive_line),
  .os_tick(os_tick), .synch_active(synch_active), .header_flag(header_flag)
);

// [bench/lsbas_lin_master.sv]
// LIN master node that drives the shared receive line.
// Assumes the caller enters a task right after a rising clock edge.
`timescale 1ns/10ps
module lsbas_lin_master (
  input  wire logic pclk,
  output logic      receive_line
);
  // Bus has a pull-up, so a released line reads recessive
  initial receive_line = 1'b1;

  task automatic hold_bits(input logic lvl, input int bits, input int bit_cyc);
    receive_line <= lvl;
    repeat (bits * bit_cyc) @(posedge pclk);
  endtask

  // Thirteen dominant bits, then a recessive delimiter
  task automatic send_break(input int bit_cyc);
    @(posedge pclk);
    hold_bits(1'b0, 13, bit_cyc);
    hold_bits(1'b1, 1, bit_cyc);
  endtask

  // Start bit, LSB first, stop plus one idle bit
  task automatic send_byte(input logic [7:0] data, input int bit_cyc);
    @(posedge pclk);
    hold_bits(1'b0, 1, bit_cyc);
    for (int i = 0; i < 8; i++) hold_bits(data[i], 1, bit_cyc);
    hold_bits(1'b1, 2, bit_cyc);
  endtask
endmodule

// [bench/lsbas_tb_top.sv]
// Self-checking bench of the LIN slave baud unit.
// Assumes the checker is bound by its own file and the master model drives the line.
`timescale 1ns/10ps
`include "lsbas_cfg.svh"
`define LSBAS_CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module lsbas_tb_top;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, receive_line, os_tick, synch_active, header_flag;
  int          miscompares, comparisons, cycles;
  logic [7:0]  offs [5] = '{`LSBAS_OFF_MANT, `LSBAS_OFF_FRAC, `LSBAS_OFF_CTRL, `LSBAS_OFF_STAT, `LSBAS_OFF_DATA};

  lsbas_top u_lsbas_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .receive_line(receive_line),
    .os_tick(os_tick), .synch_active(synch_active), .header_flag(header_flag)
  );
  lsbas_lin_master u_lsbas_lin_master (.pclk(pclk), .receive_line(receive_line));

  always #50 pclk = ~pclk;

  task automatic tally_and_finish;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Hang guard, far above the few thousand clocks the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] unused;
    apb(1'b1, addr, data, unused);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    apb(1'b0, addr, 32'h0000_0000, got);
    `LSBAS_CHK(got, exp)
  endtask

  task automatic ticks(input int n, input int exp);
    int cnt;
    cnt = 0;
    // A divider change needs a few clocks before the tick rate is steady
    repeat (4) @(posedge pclk);
    repeat (n) begin
      @(negedge pclk);
      if (os_tick === 1'b1) cnt++;
    end
    `LSBAS_CHK(cnt, exp)
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(offs[i], 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    `LSBAS_CHK(pslverr, 1'b1)
    // Master mode: extended prescaler 2 gives a tick every 2 clocks
    wr(`LSBAS_OFF_CTRL, 32'h0000_0040);
    wr(`LSBAS_OFF_FRAC, 32'h0000_0002);
    ticks(64, 32);
    // Slave mode, nominal 2.0: bit time 32 clocks
    wr(`LSBAS_OFF_CTRL, 32'h0000_0060);
    wr(`LSBAS_OFF_FRAC, 32'h0000_0000);
    wr(`LSBAS_OFF_MANT, 32'h0000_0002);
    rd(`LSBAS_OFF_MANT, 32'h0000_0002);
    ticks(64, 32);
    u_lsbas_lin_master.send_byte(8'hA5, 32);
    rd(`LSBAS_OFF_STAT, 32'h0000_0004);
    rd(`LSBAS_OFF_DATA, 32'h0000_00A5);
    // Nominal stays loaded, then auto-synch; master runs at 40 clocks a bit
    wr(`LSBAS_OFF_CTRL, 32'h0000_0070);
    u_lsbas_lin_master.send_break(40);
    `LSBAS_CHK(synch_active, 1'b1)
    u_lsbas_lin_master.send_byte(8'h55, 40);
    rd(`LSBAS_OFF_MANT, 32'h0000_0002);
    rd(`LSBAS_OFF_FRAC, 32'h0000_0008);
    rd(`LSBAS_OFF_STAT, 32'h0000_0002);
    u_lsbas_lin_master.send_byte(8'h3C, 40);
    rd(`LSBAS_OFF_DATA, 32'h0000_003C);
    // Nine dominant bits of a zero character are no break
    wr(`LSBAS_OFF_STAT, 32'h0000_0002);
    // The clear lands at the access edge; look once it has settled
    @(negedge pclk);
    `LSBAS_CHK(header_flag, 1'b0)
    wr(`LSBAS_OFF_CTRL, 32'h0000_0060);
    u_lsbas_lin_master.send_byte(8'h00, 40);
    rd(`LSBAS_OFF_STAT, 32'h0000_0004);
    rd(`LSBAS_OFF_DATA, 32'h0000_0000);
    // Deferred update: active divider changes only after the next character
    wr(`LSBAS_OFF_CTRL, 32'h0000_00E0);
    wr(`LSBAS_OFF_MANT, 32'h0000_0003);
    rd(`LSBAS_OFF_MANT, 32'h0000_0002);
    rd(`LSBAS_OFF_STAT, 32'h0000_0008);
    u_lsbas_lin_master.send_byte(8'h81, 40);
    rd(`LSBAS_OFF_MANT, 32'h0000_0003);
    rd(`LSBAS_OFF_FRAC, 32'h0000_0000);
    rd(`LSBAS_OFF_CTRL, 32'h0000_0060);
    rd(`LSBAS_OFF_DATA, 32'h0000_0081);
    // Muted: a character is discarded, a break wakes the receiver
    wr(`LSBAS_OFF_CTRL, 32'h0000_0062);
    u_lsbas_lin_master.send_byte(8'h5A, 48);
    rd(`LSBAS_OFF_STAT, 32'h0000_0000);
    u_lsbas_lin_master.send_break(48);
    rd(`LSBAS_OFF_CTRL, 32'h0000_0060);
    rd(`LSBAS_OFF_STAT, 32'h0000_0002);
    tally_and_finish();
  end
endmodule
